//--- rtl/ut_fault_pkg.sv
`default_nettype none
package ut_fault_pkg;
   // command codes on the management port
   localparam logic [7:0] CMD_UT_WARN_LIMIT   = 8'h52; // warning threshold, linear-11
   localparam logic [7:0] CMD_FAULT_THRESHOLD = 8'h53; // fault threshold, linear-11
   localparam logic [7:0] CMD_UT_FAULT_ACTION = 8'h54; // response bit fields

   // decoded temperature: signed fixed point, 16 fraction bits
   localparam int VAL_W     = 48;
   localparam int FRAC_BITS = 16;
   localparam int SHIFT_W   = 5;

   // reset values, encoded and decoded
   localparam logic [15:0]             THR_RST_WORD  = 16'he530;        // -45 degC
   localparam logic signed [VAL_W-1:0] THR_RST_VAL   = -48'sd2949120;   // -45 * 2^16
   localparam logic [15:0]             WARN_RST_WORD = 16'hdc40;        // -30 degC
   localparam logic signed [VAL_W-1:0] WARN_RST_VAL  = -48'sd1966080;   // -30 * 2^16
   localparam logic [7:0]              ACTION_RST    = 8'h80;           // disable, no retry

   // accepted threshold range, -55 .. +25 degC
   localparam logic signed [VAL_W-1:0] LIMIT_MIN = -48'sd3604480;
   localparam logic signed [VAL_W-1:0] LIMIT_MAX = 48'sd1638400;

   // response field layout
   localparam int ACT_BEHAV_HI = 7;
   localparam int ACT_BEHAV_LO = 6;
   localparam int ACT_RETRY_HI = 5;
   localparam int ACT_RETRY_LO = 3;
   localparam int ACT_DELAY_HI = 2;
   localparam int ACT_DELAY_LO = 0;
   localparam logic [1:0] BEHAV_DISABLE_RETRY = 2'h2;
   localparam logic [2:0] RETRY_NONE          = 3'h0;

   // retry time unit
   localparam longint CLK_HZ          = 40000000;
   localparam longint RETRY_UNIT_MS   = 35;
   localparam longint RETRY_UNIT_CYC  = (RETRY_UNIT_MS * CLK_HZ) / 1000;

   // supervisor states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,  // output commanded off
      ST_RUN     = 3'b001,  // output enabled
      ST_LATCHED = 3'b010,  // disabled until restart
      ST_RETRY   = 3'b011   // disabled, waiting for delay and warm-up
   } sup_state_t;
endpackage
`default_nettype wire

//--- rtl/lin11_if.sv
`default_nettype none
// carries one linear-11 word to a decoder and the decoded value back
interface lin11_if;
   import ut_fault_pkg::*;
   logic [15:0]             word;  // exponent 15:11, mantissa 10:0
   logic signed [VAL_W-1:0] value; // mantissa * 2^exponent, 16 fraction bits
   modport dec  (input word, output value);
   modport user (output word, input value);
endinterface
`default_nettype wire

//--- rtl/linear11_decode.sv
`default_nettype none
module linear11_decode
   import ut_fault_pkg::*;
(
   // word in, value out
   lin11_if.dec bus
);
   logic signed [4:0]       expo;   // signed exponent
   logic signed [10:0]      mant;   // signed mantissa
   logic [SHIFT_W-1:0]      shamt;  // exponent + 16, always 0..31
   logic signed [VAL_W-1:0] mant_x; // mantissa sign-extended

   // adding 16 to a 5-bit two's complement number flips its top bit
   always_comb
   begin
      expo   = bus.word[15:11];
      mant   = bus.word[10:0];
      shamt  = {~expo[4], expo[3:0]};
      mant_x = VAL_W'(mant);
      bus.value = mant_x <<< shamt;
   end
endmodule // linear11_decode
`default_nettype wire

//--- rtl/under_temp_fault_response.sv
// Behaviour
// - threshold is linear-11, mantissa times two^exponent
// - out-of-range threshold writes rejected, old kept
// - threshold resets to -45 degC; at-or-below faults
// - retry waits until temperature above warning
// - response byte resets to disable, no retry
// - code 10 disables output and retries
// - fault drives alert low, sticky status bit
// - retry 000 keeps output off until restart
// - nonzero retry repeats until off or shutdown
// - retry interval is (delay+1) times 35 ms
// - warning sets summary and warning bits, alerts
`default_nettype none
module under_temp_fault_response
   import ut_fault_pkg::*;
#(
   parameter longint RETRY_UNIT_CYCLES = RETRY_UNIT_CYC // cycles per 35 ms step
)
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // management command port
   input  wire logic        cmd_write_i,   // one-cycle write strobe
   input  wire logic        cmd_read_i,    // one-cycle read strobe
   input  wire logic [7:0]  cmd_code_i,    // command code
   input  wire logic [15:0] cmd_wdata_i,   // write data
   input  wire logic        clear_faults_i,// clear-faults command pulse
   output logic      [15:0] cmd_rdata_o,   // read data, registered
   output logic             cmd_rvalid_o,  // read data valid pulse
   output logic             cmd_reject_o,  // write refused pulse
   // temperature measurement
   input  wire logic        temp_valid_i,  // new measurement pulse
   input  wire logic [15:0] temp_i,        // measurement, linear-11
   // power stage control
   input  wire logic        enable_i,      // enable pin and operation command
   input  wire logic        other_fault_i, // another fault shuts the unit down
   output logic             output_en_o,   // output stage enable
   // status and alert
   output logic             ut_fault_sts_o,// sticky under-temperature fault
   output logic             ut_warn_sts_o, // sticky under-temperature warning
   output logic             temp_sum_o,    // temperature summary bit
   output logic             alert_out_n_o  // alert line, active low
);
   import ut_fault_pkg::*;

   localparam int UNIT_W = $clog2(RETRY_UNIT_CYCLES + 1);
   localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(RETRY_UNIT_CYCLES - 1);

   // whole state of the block
   typedef struct packed {
      sup_state_t              state;      // supervisor state
      logic [15:0]             thr_word;   // fault threshold as written
      logic signed [VAL_W-1:0] thr_val;    // fault threshold decoded
      logic [15:0]             warn_word;  // warning threshold as written
      logic signed [VAL_W-1:0] warn_val;   // warning threshold decoded
      logic [7:0]              action;     // response byte
      logic                    fault_sts;  // sticky fault bit
      logic                    warn_sts;   // sticky warning bit
      logic                    warm;       // last reading above warning
      logic [UNIT_W-1:0]       unit_cnt;   // cycles within one 35 ms step
      logic [2:0]              step_cnt;   // whole steps elapsed
      logic                    delay_done; // retry interval has run out
      logic [15:0]             rdata;      // read data
      logic                    rvalid;     // read answer pulse
      logic                    reject;     // write refused pulse
   } ut_state_t;

   ut_state_t st_reg;   // registered state
   ut_state_t st_next;  // next state

   // decoders: one for write data, one for measurements
   lin11_if wr_bus ();
   lin11_if tm_bus ();

   assign wr_bus.word = cmd_wdata_i;
   assign tm_bus.word = temp_i;

   linear11_decode u_wr_decode
   (
      .bus (wr_bus.dec)
   );

   linear11_decode u_tm_decode
   (
      .bus (tm_bus.dec)
   );

   // combinational helpers
   logic       wr_in_range;   // decoded write within accepted range
   logic       wr_thr;        // write to fault threshold
   logic       wr_warn;       // write to warning threshold
   logic       wr_act;        // write to response byte
   logic       fault_ev;      // measurement at or below fault threshold
   logic       warn_ev;       // measurement at or below warning threshold
   logic       meas_warm;     // measurement above warning threshold
   logic       retry_mode;    // response asks for retry
   logic       stop_retry;    // commanded off or shut down elsewhere
   logic [2:0] delay_sel;     // delay field
   logic [2:0] retry_sel;     // retry field
   logic [1:0] behav_sel;     // behaviour field

   // command decode and comparisons
   always_comb
   begin
      wr_in_range = (wr_bus.value >= LIMIT_MIN) && (wr_bus.value <= LIMIT_MAX);
      wr_thr      = cmd_write_i && (cmd_code_i == CMD_FAULT_THRESHOLD);
      wr_warn     = cmd_write_i && (cmd_code_i == CMD_UT_WARN_LIMIT);
      wr_act      = cmd_write_i && (cmd_code_i == CMD_UT_FAULT_ACTION);
      // comparison in decoded units, so any exponent compares correctly
      fault_ev    = temp_valid_i && (tm_bus.value <= st_reg.thr_val);
      warn_ev     = temp_valid_i && (tm_bus.value <= st_reg.warn_val);
      meas_warm   = tm_bus.value > st_reg.warn_val;
      behav_sel   = st_reg.action[ACT_BEHAV_HI:ACT_BEHAV_LO];
      retry_sel   = st_reg.action[ACT_RETRY_HI:ACT_RETRY_LO];
      delay_sel   = st_reg.action[ACT_DELAY_HI:ACT_DELAY_LO];
      retry_mode  = (behav_sel == BEHAV_DISABLE_RETRY) && (retry_sel != RETRY_NONE);
      stop_retry  = !enable_i || other_fault_i;
   end

   // next-state logic
   always_comb
   begin
      st_next        = st_reg;
      st_next.rvalid = 1'b0;
      st_next.reject = 1'b0;

      // threshold writes: out-of-range values leave the old setting alone
      if (wr_thr)
      begin
         if (wr_in_range)
         begin
            st_next.thr_word = cmd_wdata_i;
            st_next.thr_val  = wr_bus.value;
         end
         else
         begin
            st_next.reject = 1'b1;
         end
      end
      if (wr_warn)
      begin
         // the host is trusted to keep this above the fault threshold
         if (wr_in_range)
         begin
            st_next.warn_word = cmd_wdata_i;
            st_next.warn_val  = wr_bus.value;
         end
         else
         begin
            st_next.reject = 1'b1;
         end
      end
      // response byte: unused behaviour codes are refused
      if (wr_act)
      begin
         if (cmd_wdata_i[ACT_BEHAV_HI:ACT_BEHAV_LO] == BEHAV_DISABLE_RETRY)
         begin
            st_next.action = cmd_wdata_i[7:0];
         end
         else
         begin
            st_next.reject = 1'b1;
         end
      end
      // unknown write codes are refused as well
      if (cmd_write_i && !wr_thr && !wr_warn && !wr_act)
      begin
         st_next.reject = 1'b1;
      end

      // read answer one cycle after the strobe, zero for unknown codes
      if (cmd_read_i)
      begin
         st_next.rvalid = 1'b1;
         case (cmd_code_i)
            CMD_FAULT_THRESHOLD: st_next.rdata = st_reg.thr_word;
            CMD_UT_WARN_LIMIT:   st_next.rdata = st_reg.warn_word;
            CMD_UT_FAULT_ACTION: st_next.rdata = {8'h00, st_reg.action};
            default:             st_next.rdata = 16'h0000;
         endcase
      end

      // sticky status: clear first, so a same-cycle event wins
      if (clear_faults_i)
      begin
         st_next.fault_sts = 1'b0;
         st_next.warn_sts  = 1'b0;
      end
      if (warn_ev)
      begin
         st_next.warn_sts = 1'b1;
      end
      if (temp_valid_i)
      begin
         st_next.warm = meas_warm;
      end

      // retry interval counter, runs only while waiting to retry
      if (st_reg.state == ST_RETRY && !st_reg.delay_done)
      begin
         if (st_reg.unit_cnt == UNIT_LAST)
         begin
            st_next.unit_cnt = '0;
            if (st_reg.step_cnt == delay_sel)
            begin
               st_next.delay_done = 1'b1;
            end
            else
            begin
               st_next.step_cnt = st_reg.step_cnt + 3'h1;
            end
         end
         else
         begin
            st_next.unit_cnt = st_reg.unit_cnt + UNIT_W'(1);
         end
      end

      // supervisor
      case (st_reg.state)
         ST_IDLE:
         begin
            // output held off while commanded off or shut down
            if (!stop_retry)
            begin
               st_next.state = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (fault_ev)
            begin
               st_next.fault_sts  = 1'b1;
               st_next.unit_cnt   = '0;
               st_next.step_cnt   = 3'h0;
               st_next.delay_done = 1'b0;
               // the interval counts from the moment the fault is seen
               st_next.state = retry_mode ? ST_RETRY : ST_LATCHED;
               st_next.warm  = 1'b0;
            end
            else if (stop_retry)
            begin
               st_next.state = ST_IDLE;
            end
         end
         ST_LATCHED:
         begin
            // stays off until reset; clear-faults does not restart it
            st_next.state = ST_LATCHED;
         end
         ST_RETRY:
         begin
            if (stop_retry)
            begin
               st_next.state = ST_IDLE;
            end
            else if (st_reg.delay_done && st_reg.warm)
            begin
               st_next.state = ST_RUN;
            end
         end
         default:
         begin
            st_next.state = ST_LATCHED;
         end
      endcase

      // a fault seen while not running still latches the status bit
      if (fault_ev)
      begin
         st_next.fault_sts = 1'b1;
      end
   end

   // state register
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_reg.state      <= ST_IDLE;
         st_reg.thr_word   <= THR_RST_WORD;
         st_reg.thr_val    <= THR_RST_VAL;
         st_reg.warn_word  <= WARN_RST_WORD;
         st_reg.warn_val   <= WARN_RST_VAL;
         st_reg.action     <= ACTION_RST;
         st_reg.fault_sts  <= 1'b0;
         st_reg.warn_sts   <= 1'b0;
         st_reg.warm       <= 1'b0;
         st_reg.unit_cnt   <= '0;
         st_reg.step_cnt   <= 3'h0;
         st_reg.delay_done <= 1'b0;
         st_reg.rdata      <= 16'h0000;
         st_reg.rvalid     <= 1'b0;
         st_reg.reject     <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs, all taken from registered state
   assign cmd_rdata_o    = st_reg.rdata;
   assign cmd_rvalid_o   = st_reg.rvalid;
   assign cmd_reject_o   = st_reg.reject;
   assign output_en_o    = (st_reg.state == ST_RUN);
   assign ut_fault_sts_o = st_reg.fault_sts;
   assign ut_warn_sts_o  = st_reg.warn_sts;
   // summary covers both temperature conditions
   assign temp_sum_o     = st_reg.fault_sts | st_reg.warn_sts;
   // alert stays low until clear-faults drops every sticky bit
   assign alert_out_n_o  = !(st_reg.fault_sts | st_reg.warn_sts);

endmodule // under_temp_fault_response
`default_nettype wire

//--- verification/ut_fault_props.sv
`default_nettype none
module ut_fault_props
   import ut_fault_pkg::*;
#(
   parameter longint RETRY_UNIT_CYCLES = RETRY_UNIT_CYC // cycles per retry unit
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // inputs watched
   input wire logic cmd_write_i,
   input wire logic cmd_read_i,
   input wire logic clear_faults_i,
   input wire logic temp_valid_i,
   input wire logic enable_i,
   input wire logic other_fault_i,
   // outputs watched
   input wire logic cmd_rvalid_o,
   input wire logic cmd_reject_o,
   input wire logic output_en_o,
   input wire logic ut_fault_sts_o,
   input wire logic ut_warn_sts_o,
   input wire logic alert_out_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] gap_cnt;   // cycles since the output last dropped
   logic        fault_off; // the last drop came from a fault while running
   // a fall with enable on and no other fault can only be the fault path
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gap_cnt   <= 32'h0;
         fault_off <= 1'b0;
      end
      else if ($fell(output_en_o))
      begin
         gap_cnt   <= 32'h0;
         fault_off <= ut_fault_sts_o && $past(enable_i) && !$past(other_fault_i);
      end
      else
      begin
         gap_cnt   <= gap_cnt + 32'h1;
         fault_off <= output_en_o ? 1'b0 : fault_off;
      end
   end
   fault_alert_a: assert property ($rose(ut_fault_sts_o) |-> !alert_out_n_o)
      else $error("alert not low on fault");
   fault_sticky_a: assert property (ut_fault_sts_o && !clear_faults_i |=> ut_fault_sts_o)
      else $error("fault bit lost without clear");
   fault_cause_a: assert property ($rose(ut_fault_sts_o) |-> $past(temp_valid_i))
      else $error("fault bit set without measurement");
   fault_off_a: assert property ($rose(ut_fault_sts_o) && $past(output_en_o)
      && $past(enable_i) && !$past(other_fault_i) |-> !output_en_o) else $error("output kept on");
   warn_alert_a: assert property ($rose(ut_warn_sts_o) |-> !alert_out_n_o)
      else $error("alert not low on warning");
   off_cmd_a: assert property (!enable_i || other_fault_i |=> !output_en_o)
      else $error("output on while commanded off");
   read_answer_a: assert property (cmd_read_i |=> cmd_rvalid_o)
      else $error("read not answered");
   reject_cause_a: assert property (cmd_reject_o |-> $past(cmd_write_i))
      else $error("refusal without write");
   retry_gap_a: assert property ($rose(output_en_o) && fault_off
      |-> gap_cnt >= RETRY_UNIT_CYCLES - 2) else $error("restart too early");
endmodule // ut_fault_props
bind under_temp_fault_response ut_fault_props #(.RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)) props (
   .core_clk_i, .rst_i, .cmd_write_i, .cmd_read_i, .clear_faults_i, .temp_valid_i,
   .enable_i, .other_fault_i, .cmd_rvalid_o, .cmd_reject_o, .output_en_o,
   .ut_fault_sts_o, .ut_warn_sts_o, .alert_out_n_o);
`default_nettype wire

//--- verification/host_model.sv
`default_nettype none
module host_model
(
   // clock and answers
   input  wire logic        clk_i,
   input  wire logic [15:0] rdata_i,
   input  wire logic        rvalid_i,
   input  wire logic        reject_i,
   // command strobes
   output var  logic        write_o,
   output var  logic        read_o,
   output var  logic        clear_o,
   output var  logic [7:0]  code_o,
   output var  logic [15:0] wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle bus at time zero
   initial
   begin
      {write_o, read_o, clear_o, code_o, wdata_o} = '0;
   end
   // one-cycle strobe; code and data flip afterwards so stale values never look valid
   task automatic access(input logic wr, input logic [7:0] c, input logic [15:0] d,
                         output logic [15:0] q);
      @(posedge clk_i);
      write_o <= wr;
      read_o  <= !wr;
      code_o  <= c;
      wdata_o <= d;
      @(posedge clk_i);
      {write_o, read_o} <= 2'h0;
      code_o  <= ~c;
      wdata_o <= ~d;
      #1;
      q = wr ? {15'h0, reject_i} : (rvalid_i ? rdata_i : 16'hxxxx);
   endtask
   // clear-faults command pulse
   task automatic clear_cmd();
      @(posedge clk_i) clear_o <= 1'b1;
      @(posedge clk_i) clear_o <= 1'b0;
      #1;
   endtask
endmodule // host_model
`default_nettype wire

//--- verification/testbench.sv
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ut_fault_pkg::*;
   localparam longint UNIT = 10; // short retry unit keeps the run brief
   typedef struct packed {
      logic wr; logic [7:0] code; logic [15:0] wd; logic rej; logic [15:0] rd;
   } row_t;
   // write (or read only), then the expected refusal and read-back
   row_t rows [15] = '{
      '{1'b0, 8'h53, 16'h0000, 1'b0, 16'he530}, '{1'b0, 8'h54, 16'h0000, 1'b0, 16'h0080},
      '{1'b1, 8'h53, 16'h07c8, 1'b1, 16'he530}, '{1'b1, 8'h53, 16'h07c9, 1'b0, 16'h07c9},
      '{1'b1, 8'h53, 16'h001a, 1'b1, 16'h07c9}, '{1'b1, 8'h53, 16'h0019, 1'b0, 16'h0019},
      '{1'b1, 8'h53, 16'h0fe4, 1'b1, 16'h0019}, '{1'b1, 8'h53, 16'h0fe7, 1'b0, 16'h0fe7},
      '{1'b1, 8'h54, 16'h0000, 1'b1, 16'h0080}, '{1'b1, 8'h54, 16'h0040, 1'b1, 16'h0080},
      '{1'b1, 8'h54, 16'h00c0, 1'b1, 16'h0080}, '{1'b1, 8'h54, 16'h008a, 1'b0, 16'h008a},
      '{1'b1, 8'h53, 16'he530, 1'b0, 16'he530}, '{1'b1, 8'h52, 16'h07c8, 1'b1, 16'hdc40},
      '{1'b1, 8'h55, 16'h0019, 1'b1, 16'h0000}};
   logic core_clk_i, rst_i, temp_valid_i, enable_i, other_fault_i;
   logic cmd_write_i, cmd_read_i, clear_faults_i, cmd_rvalid_o, cmd_reject_o;
   logic output_en_o, ut_fault_sts_o, ut_warn_sts_o, temp_sum_o, alert_out_n_o;
   logic [7:0]  cmd_code_i;
   logic [15:0] cmd_wdata_i, cmd_rdata_o, temp_i, q;
   int          fails, checks_done;
   host_model host (.clk_i(core_clk_i), .rdata_i(cmd_rdata_o), .rvalid_i(cmd_rvalid_o),
      .reject_i(cmd_reject_o), .write_o(cmd_write_i), .read_o(cmd_read_i),
      .clear_o(clear_faults_i), .code_o(cmd_code_i), .wdata_o(cmd_wdata_i));
   under_temp_fault_response #(.RETRY_UNIT_CYCLES(UNIT)) dut (.core_clk_i, .rst_i,
      .cmd_write_i, .cmd_read_i, .cmd_code_i, .cmd_wdata_i, .clear_faults_i, .cmd_rdata_o,
      .cmd_rvalid_o, .cmd_reject_o, .temp_valid_i, .temp_i, .enable_i, .other_fault_i,
      .output_en_o, .ut_fault_sts_o, .ut_warn_sts_o, .temp_sum_o, .alert_out_n_o);
   // 40 MHz clock
   initial
   begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   // counts, verdict, end of run
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one measurement pulse; status is settled on return
   task automatic meas(input logic [15:0] w);
      @(posedge core_clk_i);
      temp_valid_i <= 1'b1;
      temp_i       <= w;
      @(posedge core_clk_i) temp_valid_i <= 1'b0;
      #1;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // bounded wait on the output enable; running out ends the run
   task automatic wait_en(input logic v, input int n);
      for (int k = 0; k < n && output_en_o !== v; k++)
         cyc(1);
      `CHK(output_en_o, v)
      if (output_en_o !== v) results();
   endtask
   initial
   begin
      {rst_i, temp_valid_i, enable_i, other_fault_i, temp_i} = {1'b1, 19'h0};
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i])
      begin
         host.access(rows[i].wr, rows[i].code, rows[i].wd, q);
         if (rows[i].wr) `CHK(q[0], rows[i].rej)
         host.access(1'b0, rows[i].code, 16'h0, q);
         `CHK(q, rows[i].rd)
      end
      // -44 degC warns only; -45 degC is a fault
      @(posedge core_clk_i) enable_i <= 1'b1;
      wait_en(1'b1, 4);
      meas(16'h07d4);
      `CHK({ut_fault_sts_o, ut_warn_sts_o, temp_sum_o, alert_out_n_o, output_en_o}, 5'h0d)
      host.clear_cmd();
      meas(16'h07d3);
      `CHK({ut_fault_sts_o, alert_out_n_o, output_en_o}, 3'h4)
      // still below warning after the delay: no restart
      meas(16'h07d8);
      cyc(40);
      `CHK({ut_fault_sts_o, output_en_o}, 2'h2)
      meas(16'h0000);
      wait_en(1'b1, 3);
      // delay code 2 gives three units from the fault edge
      meas(16'h07ce);
      meas(16'h0000);
      cyc(23);
      `CHK(output_en_o, 1'b0)
      wait_en(1'b1, 12);
      // commanded off during retry, then another fault
      meas(16'h07ce);
      @(posedge core_clk_i) enable_i <= 1'b0;
      meas(16'h0000);
      cyc(40);
      `CHK(output_en_o, 1'b0)
      @(posedge core_clk_i) enable_i <= 1'b1;
      wait_en(1'b1, 4);
      @(posedge core_clk_i) other_fault_i <= 1'b1;
      cyc(2);
      `CHK(output_en_o, 1'b0)
      @(posedge core_clk_i) other_fault_i <= 1'b0;
      // reset in mid-run restores the response byte and threshold
      @(posedge core_clk_i) rst_i <= 1'b1;
      cyc(2);
      `CHK({output_en_o, ut_fault_sts_o, alert_out_n_o}, 3'h1)
      @(posedge core_clk_i) rst_i <= 1'b0;
      host.access(1'b0, CMD_UT_FAULT_ACTION, 16'h0, q);
      `CHK(q, {8'h00, ACTION_RST})
      host.access(1'b0, CMD_FAULT_THRESHOLD, 16'h0, q);
      `CHK(q, THR_RST_WORD)
      // no-retry default stays off, clear only drops the status
      wait_en(1'b1, 4);
      meas(16'h07ce);
      meas(16'h0000);
      cyc(50);
      `CHK(output_en_o, 1'b0)
      host.clear_cmd();
      cyc(3);
      `CHK({ut_fault_sts_o, alert_out_n_o, output_en_o}, 3'h2)
      // clear and a new fault on the same edge: the fault must win
      fork
         host.clear_cmd();
         meas(16'h07ce);
      join
      `CHK({ut_fault_sts_o, alert_out_n_o}, 2'h2)
      results();
   end
endmodule // testbench
`default_nettype wire
